// >>> sleep_ctrl_regs.vh
// Operation
// - mode 1 sleeps and wakes by request pin
// - modes 4 and 5 run cyclic sleep
// - mode 5 also wakes on request falling edge
// - mode 4 ignores the request pin
// - poll parent every 100 ms while awake
// - receiver on until parent acknowledgment
// - pending data keeps receiver on, else off
// - sleep status low asleep, high awake
// - flow control: clear-to-send high asleep, low awake
// - association indicator low throughout sleep
// - request pin pulled down during sleep
// - no serial or radio response while asleep
// - unjoined wake scans channel mask channels
// - pin sleep waits for busy work first
// - host lowers request pin to wake
// - first poll within 1-2 ms of pin wake
// - cyclic: stay awake on data, else sleep
// - data restarts stay-awake timer from setting
// - sleep on timer expiry or sleep command
// - sleep period 0x20 to 0xaf0 in 10 ms
// - multiplier 1 to 0xffff
// - option 0x02 always wakes full stay time
// - multiplier gates status raise, radio data immediate
`ifndef SLEEP_CTRL_REGS_VH
`define SLEEP_CTRL_REGS_VH
`define ADDR_MODE        4'h0
`define ADDR_PERIOD      4'h1
`define ADDR_MULT        4'h2
`define ADDR_STAY        4'h3
`define ADDR_OPTIONS     4'h4
`define ADDR_PINCFG      4'h5
`define ADDR_SCANMASK    4'h6
`define ADDR_STATUS      4'h7
`define ADDR_COMMAND     4'h8
`define MODE_PIN         3'h1
`define MODE_CYC         3'h4
`define MODE_CYC_PIN     3'h5
`define PERIOD_MIN       12'h020
`define PERIOD_MAX       12'haf0
`define PERIOD_RST       12'h020
`define MULT_MIN         16'h0001
`define MULT_RST         16'h0001
`define STAY_RST         16'h0064
`define OPT_FULL_WAKE    1
`define PIN_FC_EN        0
`define PIN_ASSOC_EN     1
`define CMD_SLEEP_NOW    0
`define CLK_MHZ          125
`define TICK_MS          10
`define TICK_CYC         (`TICK_MS * 1000 * `CLK_MHZ)
`define POLL_MS          100
`define POLL_TICKS       (`POLL_MS / `TICK_MS)
`define WAKE_POLL_US     1000
`define WAKE_POLL_CYC    (`WAKE_POLL_US * `CLK_MHZ)
`endif

// >>> tick_div.v
`include "sleep_ctrl_regs.vh"
module tick_div #(
   parameter CYCLES = `TICK_CYC
) (
   input  wire clk_i,
   input  wire nrst_i,
   input  wire clr_i,
   output reg  tick_o
);
   reg [31:0] cnt_q;
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_q  <= 32'h0;
         tick_o <= 1'b0;
      end else if (clr_i) begin
         cnt_q  <= 32'h0;
         tick_o <= 1'b0;
      end else if (cnt_q == CYCLES - 1) begin
         cnt_q  <= 32'h0;
         tick_o <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + 32'h1;
         tick_o <= 1'b0;
      end
   end
endmodule

// >>> sleep_ctrl.v
`include "sleep_ctrl_regs.vh"
module sleep_ctrl #(
   parameter TICK_CYCLES = `TICK_CYC,
   parameter WAKE_POLL   = `WAKE_POLL_CYC,
   parameter CHANNELS    = 16
) (
   input  wire                clk_i,
   input  wire                nrst_i,
   input  wire [3:0]          addr_i,
   input  wire [31:0]         wdata_i,
   input  wire                wr_i,
   input  wire                rd_i,
   output reg  [31:0]         rdata_o,
   input  wire                sleep_request_in_i,
   input  wire                busy_i,
   input  wire                joined_i,
   input  wire                serial_rx_i,
   input  wire                radio_rx_i,
   input  wire                ack_i,
   input  wire                ack_pending_i,
   input  wire                scan_done_i,
   output reg                 poll_req_o,
   output reg                 rx_en_o,
   output reg                 sleep_status_o,
   output reg                 cts_n_o,
   output reg                 assoc_o,
   input  wire                assoc_run_i,
   output reg                 req_pulldown_o,
   output reg                 data_en_o,
   output reg                 scan_start_o,
   output reg  [CHANNELS-1:0] scan_mask_o
);
   localparam S_AWAKE = 2'h0;
   localparam S_DRAIN = 2'h1;
   localparam S_SLEEP = 2'h2;

   reg [2:0]          sleep_mode_select_q;
   reg [11:0]         sleep_period_q;
   reg [15:0]         sleep_period_multiplier_q;
   reg [15:0]         stay_awake_time_q;
   reg [7:0]          options_q;
   reg [1:0]          pin_cfg_q;
   reg [CHANNELS-1:0] channel_scan_mask_q;
   reg [1:0]          state_q;
   reg [11:0]         period_cnt_q;
   reg [15:0]         mult_cnt_q;
   reg [15:0]         stay_cnt_q;
   reg                stay_run_q;
   reg [3:0]          poll_cnt_q;
   reg                wait_ack_q;
   reg                got_data_q;
   reg                first_poll_q;
   reg [31:0]         wake_cnt_q;
   reg                req_q;
   reg                status_raise_q;
   reg                sleep_cmd_q;
   wire               tick;
   wire               asleep;
   wire               cyclic;
   wire               any_rx;
   wire               wake_pin;
   wire               wake_timer;

   tick_div #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .clr_i  (1'b0),
      .tick_o (tick)
   );

   assign asleep = (state_q == S_SLEEP);
   assign cyclic = (sleep_mode_select_q == `MODE_CYC) ||
                   (sleep_mode_select_q == `MODE_CYC_PIN);
   assign any_rx = !asleep && (serial_rx_i || radio_rx_i);
   assign wake_pin = ((sleep_mode_select_q == `MODE_PIN) && !sleep_request_in_i) ||
                     ((sleep_mode_select_q == `MODE_CYC_PIN) && req_q &&
                      !sleep_request_in_i);
   assign wake_timer = cyclic && tick && (period_cnt_q <= 12'h1);

   // register writes
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sleep_mode_select_q       <= 3'h0;
         sleep_period_q            <= `PERIOD_RST;
         sleep_period_multiplier_q <= `MULT_RST;
         stay_awake_time_q         <= `STAY_RST;
         options_q                 <= 8'h0;
         pin_cfg_q                 <= 2'h0;
         channel_scan_mask_q       <= {CHANNELS{1'b1}};
         sleep_cmd_q               <= 1'b0;
      end else begin
         sleep_cmd_q <= 1'b0;
         if (wr_i) begin
            case (addr_i)
               `ADDR_MODE: sleep_mode_select_q <= wdata_i[2:0];
               `ADDR_PERIOD: begin
                  if (wdata_i[11:0] < `PERIOD_MIN)
                     sleep_period_q <= `PERIOD_MIN;
                  else if (wdata_i[11:0] > `PERIOD_MAX || wdata_i[31:12] != 20'h0)
                     sleep_period_q <= `PERIOD_MAX;
                  else
                     sleep_period_q <= wdata_i[11:0];
               end
               `ADDR_MULT: begin
                  if (wdata_i[15:0] == 16'h0)
                     sleep_period_multiplier_q <= `MULT_MIN;
                  else
                     sleep_period_multiplier_q <= wdata_i[15:0];
               end
               `ADDR_STAY: stay_awake_time_q <= wdata_i[15:0];
               `ADDR_OPTIONS: options_q <= wdata_i[7:0];
               `ADDR_PINCFG: pin_cfg_q <= wdata_i[1:0];
               `ADDR_SCANMASK: channel_scan_mask_q <= wdata_i[CHANNELS-1:0];
               `ADDR_COMMAND: sleep_cmd_q <= wdata_i[`CMD_SLEEP_NOW];
               default: ;
            endcase
         end
      end
   end

   // register reads
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_o <= 32'h0;
      end else if (rd_i) begin
         case (addr_i)
            `ADDR_MODE: rdata_o <= {29'h0, sleep_mode_select_q};
            `ADDR_PERIOD: rdata_o <= {20'h0, sleep_period_q};
            `ADDR_MULT: rdata_o <= {16'h0, sleep_period_multiplier_q};
            `ADDR_STAY: rdata_o <= {16'h0, stay_awake_time_q};
            `ADDR_OPTIONS: rdata_o <= {24'h0, options_q};
            `ADDR_PINCFG: rdata_o <= {30'h0, pin_cfg_q};
            `ADDR_SCANMASK: rdata_o <= {{(32-CHANNELS){1'b0}}, channel_scan_mask_q};
            `ADDR_STATUS: rdata_o <= {26'h0, stay_run_q, got_data_q, wait_ack_q,
                                      sleep_status_o, state_q};
            default: rdata_o <= 32'h0;
         endcase
      end else begin
         rdata_o <= 32'h0;
      end
   end

   // main sequencer
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q        <= S_AWAKE;
         period_cnt_q   <= 12'h0;
         mult_cnt_q     <= 16'h0;
         stay_cnt_q     <= 16'h0;
         stay_run_q     <= 1'b0;
         poll_cnt_q     <= 4'h0;
         wait_ack_q     <= 1'b0;
         got_data_q     <= 1'b0;
         first_poll_q   <= 1'b0;
         wake_cnt_q     <= 32'h0;
         req_q          <= 1'b0;
         status_raise_q <= 1'b1;
         poll_req_o     <= 1'b0;
         rx_en_o        <= 1'b0;
         sleep_status_o <= 1'b1;
         cts_n_o        <= 1'b0;
         assoc_o        <= 1'b0;
         req_pulldown_o <= 1'b0;
         data_en_o      <= 1'b1;
         scan_start_o   <= 1'b0;
         scan_mask_o    <= {CHANNELS{1'b0}};
      end else begin
         req_q        <= sleep_request_in_i;
         poll_req_o   <= 1'b0;
         scan_start_o <= 1'b0;
         scan_mask_o  <= channel_scan_mask_q;
         case (state_q)
            S_AWAKE: begin
               sleep_status_o <= status_raise_q || (radio_rx_i && !asleep);
               if (radio_rx_i)
                  status_raise_q <= 1'b1;
               cts_n_o        <= pin_cfg_q[`PIN_FC_EN] ? 1'b0 : 1'b0;
               assoc_o        <= pin_cfg_q[`PIN_ASSOC_EN] ? assoc_run_i : 1'b0;
               req_pulldown_o <= 1'b0;
               data_en_o      <= 1'b1;
               // data taken after a pending ack; a new poll below reopens the receiver
               if (got_data_q && !ack_i && radio_rx_i)
                  rx_en_o <= 1'b0;
               // first poll shortly after wake, then every 100 ms
               if (first_poll_q) begin
                  if (wake_cnt_q >= WAKE_POLL - 1) begin
                     first_poll_q <= 1'b0;
                     poll_req_o   <= joined_i;
                     wait_ack_q   <= joined_i;
                     rx_en_o      <= joined_i;
                     poll_cnt_q   <= 4'h0;
                  end else begin
                     wake_cnt_q <= wake_cnt_q + 32'h1;
                  end
               end else if (tick) begin
                  if (poll_cnt_q >= `POLL_TICKS - 1) begin
                     poll_cnt_q <= 4'h0;
                     if (joined_i && !wait_ack_q) begin
                        poll_req_o <= 1'b1;
                        wait_ack_q <= 1'b1;
                        rx_en_o    <= 1'b1;
                     end
                  end else begin
                     poll_cnt_q <= poll_cnt_q + 4'h1;
                  end
               end
               if (wait_ack_q && ack_i) begin
                  wait_ack_q <= 1'b0;
                  rx_en_o    <= ack_pending_i;
                  got_data_q <= ack_pending_i;
                  if (cyclic && ack_pending_i) begin
                     stay_run_q <= 1'b1;
                     stay_cnt_q <= stay_awake_time_q;
                  end
               end
               if (cyclic && any_rx) begin
                  stay_run_q <= 1'b1;
                  stay_cnt_q <= stay_awake_time_q;
               end else if (stay_run_q && tick && stay_cnt_q != 16'h0) begin
                  stay_cnt_q <= stay_cnt_q - 16'h1;
               end
               // go to sleep
               if (sleep_mode_select_q == `MODE_PIN && sleep_request_in_i) begin
                  state_q <= S_DRAIN;
               end else if (cyclic && !first_poll_q) begin
                  if (sleep_cmd_q ||
                      (stay_run_q && stay_cnt_q == 16'h0 && !any_rx)) begin
                     state_q <= S_DRAIN;
                  end else if (!stay_run_q && !wait_ack_q && !any_rx &&
                               !got_data_q && !options_q[`OPT_FULL_WAKE]) begin
                     state_q <= S_DRAIN;
                  end else if (!stay_run_q && options_q[`OPT_FULL_WAKE]) begin
                     stay_run_q <= 1'b1;
                     stay_cnt_q <= stay_awake_time_q;
                  end
               end
            end
            S_DRAIN: begin
               if (sleep_mode_select_q == `MODE_PIN && !sleep_request_in_i) begin
                  state_q <= S_AWAKE;
               end else if (!busy_i && !wait_ack_q) begin
                  state_q        <= S_SLEEP;
                  sleep_status_o <= 1'b0;
                  cts_n_o        <= pin_cfg_q[`PIN_FC_EN];
                  assoc_o        <= 1'b0;
                  req_pulldown_o <= 1'b1;
                  data_en_o      <= 1'b0;
                  rx_en_o        <= 1'b0;
                  stay_run_q     <= 1'b0;
                  got_data_q     <= 1'b0;
                  period_cnt_q   <= sleep_period_q;
               end else if (tick) begin
                  // still awake while work drains, so keep polling
                  if (poll_cnt_q >= `POLL_TICKS - 1) begin
                     poll_cnt_q <= 4'h0;
                     if (joined_i && !wait_ack_q) begin
                        poll_req_o <= 1'b1;
                        wait_ack_q <= 1'b1;
                        rx_en_o    <= 1'b1;
                     end
                  end else begin
                     poll_cnt_q <= poll_cnt_q + 4'h1;
                  end
               end
               if (wait_ack_q && ack_i) begin
                  wait_ack_q <= 1'b0;
                  rx_en_o    <= ack_pending_i;
               end
            end
            S_SLEEP: begin
               if (tick && period_cnt_q != 12'h0)
                  period_cnt_q <= period_cnt_q - 12'h1;
               if (wake_pin || wake_timer) begin
                  state_q      <= S_AWAKE;
                  first_poll_q <= 1'b1;
                  wake_cnt_q   <= 32'h0;
                  poll_cnt_q   <= 4'h0;
                  scan_start_o <= !joined_i;
                  if (sleep_period_multiplier_q == 16'h1 || !cyclic ||
                      mult_cnt_q + 16'h1 >= sleep_period_multiplier_q) begin
                     mult_cnt_q     <= 16'h0;
                     status_raise_q <= 1'b1;
                  end else begin
                     mult_cnt_q     <= mult_cnt_q + 16'h1;
                     status_raise_q <= 1'b0;
                  end
               end
            end
            default: state_q <= S_AWAKE;
         endcase
      end
   end
endmodule

// >>> sleep_ctrl_props.sv
module sleep_ctrl_chk (
   input wire        clk_i,
   input wire        nrst_i,
   input wire        rd_i,
   input wire [31:0] rdata_o,
   input wire        joined_i,
   input wire        ack_i,
   input wire        ack_pending_i,
   input wire        poll_req_o,
   input wire        rx_en_o,
   input wire        sleep_status_o,
   input wire        cts_n_o,
   input wire        req_pulldown_o,
   input wire        data_en_o,
   input wire        scan_start_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   a_rx_with_poll: assert property (poll_req_o |-> rx_en_o) else $error("rx off at poll");
   a_rx_hold_ack: assert property (rx_en_o && !ack_i && data_en_o |=> rx_en_o || !data_en_o)
      else $error("rx dropped before ack");
   a_rx_pend_on: assert property (ack_i && ack_pending_i && rx_en_o |=> rx_en_o || !data_en_o)
      else $error("rx dropped with data pending");
   a_rx_idle_off: assert property (ack_i && !ack_pending_i && rx_en_o && !poll_req_o |=> !rx_en_o)
      else $error("rx left on");
   a_sleep_pins: assert property (req_pulldown_o |-> !sleep_status_o && !data_en_o)
      else $error("asleep pins wrong");
   a_cts_awake: assert property (data_en_o && sleep_status_o |-> !cts_n_o) else $error("cts");
   a_poll_awake: assert property (poll_req_o |-> data_en_o) else $error("poll asleep");
   a_rx_asleep: assert property (!data_en_o [*2] |-> !rx_en_o) else $error("rx asleep");
   a_poll_period: assert property (poll_req_o |-> ##[1:230] (poll_req_o || !data_en_o || !joined_i))
      else $error("poll period");
   a_first_poll: assert property ($rose(data_en_o) && joined_i |-> ##[1:12] poll_req_o)
      else $error("no wake poll");
   a_scan_wake: assert property (scan_start_o |-> !joined_i ##1 data_en_o) else $error("scan");
   a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0) else $error("rdata not 0");
endmodule

// >>> host_model.sv
module host_model (
   input  logic       clk_i,
   input  logic       nrst_i,
   input  logic       poll_i,
   input  logic       cts_n_i,
   input  logic [3:0] dly_i,
   input  logic       pend_i,
   input  logic       send_i,
   output logic       ack_o = 1'b0,
   output logic       pend_o = 1'b0,
   output logic       rx_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_q = 4'h0;
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_q  <= 4'h0;
         ack_o  <= 1'b0;
         pend_o <= 1'b0;
         rx_o   <= 1'b0;
      end else begin
         ack_o  <= 1'b0;
         pend_o <= ~pend_o;
         rx_o   <= send_i && !cts_n_i;
         if (poll_i) begin
            cnt_q <= dly_i;
         end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
               ack_o  <= 1'b1;
               pend_o <= pend_i;
            end
         end
      end
   end
endmodule

// >>> tb_top.sv
`include "sleep_ctrl_regs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic [3:0]  addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0;
   logic [31:0] v;
   logic        sleep_request_in_i = 1'b0;
   logic        busy_i = 1'b0;
   logic        joined_i = 1'b1;
   logic        radio_rx_i = 1'b0;
   logic        assoc_run_i = 1'b1;
   logic        pend = 1'b0;
   logic        send = 1'b0;
   logic        scan_seen = 1'b0;
   logic [3:0]  dly = 4'h2;
   wire  [31:0] rdata_o;
   wire  [15:0] scan_mask_o;
   wire         ack_i, ack_pending_i, serial_rx_i, poll_req_o, rx_en_o, sleep_status_o;
   wire         cts_n_o, assoc_o, req_pulldown_o, data_en_o, scan_start_o;
   int          err_total = 0;
   int          n_checks = 0;
   sleep_ctrl #(.TICK_CYCLES(20), .WAKE_POLL(4), .CHANNELS(16)) i_sleep_ctrl (
      .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .sleep_request_in_i(sleep_request_in_i), .busy_i(busy_i),
      .joined_i(joined_i), .serial_rx_i(serial_rx_i), .radio_rx_i(radio_rx_i), .ack_i(ack_i),
      .ack_pending_i(ack_pending_i), .scan_done_i(1'b0), .poll_req_o(poll_req_o),
      .rx_en_o(rx_en_o), .sleep_status_o(sleep_status_o), .cts_n_o(cts_n_o), .assoc_o(assoc_o),
      .assoc_run_i(assoc_run_i), .req_pulldown_o(req_pulldown_o), .data_en_o(data_en_o),
      .scan_start_o(scan_start_o), .scan_mask_o(scan_mask_o));
   host_model i_host_model (.clk_i(clk_i), .nrst_i(nrst_i), .poll_i(poll_req_o),
      .cts_n_i(cts_n_o), .dly_i(dly), .pend_i(pend), .send_i(send), .ack_o(ack_i),
      .pend_o(ack_pending_i), .rx_o(serial_rx_i));
   always #4 clk_i = ~clk_i;
   always @(posedge clk_i) if (scan_start_o) scan_seen <= 1'b1;
   always @(posedge clk_i) if (poll_req_o) dly <= 4'($urandom_range(1, 15));
   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1 chk(rdata_o, exp);
   endtask
   task automatic wait_en(input logic lvl, input int lim);
      for (int k = 0; k < lim && data_en_o !== lvl; k++) @(posedge clk_i);
      #1 chk({31'h0, data_en_o}, {31'h0, lvl});
   endtask
   task automatic chk_state(input logic s);
      #1;
      chk({31'h0, sleep_status_o}, {31'h0, !s});
      chk({31'h0, cts_n_o}, {31'h0, s});
      chk({31'h0, assoc_o}, {31'h0, !s});
      chk({31'h0, req_pulldown_o}, {31'h0, s});
   endtask
   initial begin
      void'($urandom(31));
      repeat (12) @(posedge clk_i);
      nrst_i <= 1'b1;
      rdc(`ADDR_PERIOD, 32'h20);
      rdc(`ADDR_MULT, 32'h1);
      rdc(4'hf, 32'h0);
      wr(`ADDR_PERIOD, 32'h10);
      rdc(`ADDR_PERIOD, 32'h20);
      wr(`ADDR_PERIOD, 32'hfff);
      rdc(`ADDR_PERIOD, 32'haf0);
      wr(`ADDR_MULT, 32'h0);
      rdc(`ADDR_MULT, 32'h1);
      repeat (4) begin
         v = 32'h20 + $urandom_range(0, 32'had0);
         wr(`ADDR_PERIOD, v);
         rdc(`ADDR_PERIOD, v);
         v = $urandom_range(1, 32'hffff);
         wr(`ADDR_MULT, v);
         rdc(`ADDR_MULT, v);
      end
      v = $urandom;
      wr(`ADDR_SCANMASK, v);
      @(posedge clk_i);
      #1 chk({16'h0, scan_mask_o}, {16'h0, v[15:0]});
      wr(`ADDR_PERIOD, 32'h20);
      wr(`ADDR_MULT, 32'h1);
      wr(`ADDR_STAY, 32'h5);
      wr(`ADDR_PINCFG, 32'h3);
      wr(`ADDR_MODE, 32'h1);
      pend <= 1'b1;
      busy_i <= 1'b1;
      sleep_request_in_i <= 1'b1;
      repeat (40) @(posedge clk_i);
      #1 chk({31'h0, data_en_o}, 32'h1);
      @(posedge clk_i);
      busy_i <= 1'b0;
      wait_en(1'b0, 20);
      repeat (2) @(posedge clk_i);
      chk_state(1'b1);
      repeat (700) @(posedge clk_i);
      #1 chk({31'h0, data_en_o}, 32'h0);
      @(posedge clk_i);
      sleep_request_in_i <= 1'b0;
      wait_en(1'b1, 20);
      repeat (3) @(posedge clk_i);
      chk_state(1'b0);
      repeat (300) @(posedge clk_i);
      pend <= 1'b0;
      wr(`ADDR_MODE, 32'h4);
      wait_en(1'b0, 900);
      @(posedge clk_i);
      sleep_request_in_i <= 1'b1;
      @(posedge clk_i);
      sleep_request_in_i <= 1'b0;
      repeat (30) @(posedge clk_i);
      #1 chk({31'h0, data_en_o}, 32'h0);
      wait_en(1'b1, 700);
      @(posedge clk_i);
      send <= 1'b1;
      @(posedge clk_i);
      send <= 1'b0;
      repeat (50) @(posedge clk_i);
      #1 chk({31'h0, data_en_o}, 32'h1);
      wait_en(1'b0, 250);
      wr(`ADDR_MODE, 32'h5);
      joined_i <= 1'b0;
      sleep_request_in_i <= 1'b1;
      @(posedge clk_i);
      sleep_request_in_i <= 1'b0;
      wait_en(1'b1, 10);
      @(posedge clk_i);
      radio_rx_i <= 1'b1;
      @(posedge clk_i);
      radio_rx_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      chk({31'h0, scan_seen}, 32'h1);
      wr(`ADDR_COMMAND, 32'h1);
      wait_en(1'b0, 10);
      wr(`ADDR_OPTIONS, 32'h2);
      wr(`ADDR_MULT, 32'h2);
      wr(`ADDR_MODE, 32'h4);
      joined_i <= 1'b1;
      wait_en(1'b1, 700);
      chk({31'h0, sleep_status_o}, 32'h0);
      repeat (40) @(posedge clk_i);
      #1 chk({31'h0, data_en_o}, 32'h1);
      wait_en(1'b0, 250);
      wait_en(1'b1, 700);
      chk({31'h0, sleep_status_o}, 32'h1);
      stop_test;
   end
   initial begin
      #400000;
      err_total++;
      stop_test;
   end
endmodule
bind sleep_ctrl sleep_ctrl_chk i_sleep_ctrl_chk (.clk_i(clk_i), .nrst_i(nrst_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .joined_i(joined_i), .ack_i(ack_i), .ack_pending_i(ack_pending_i),
   .poll_req_o(poll_req_o), .rx_en_o(rx_en_o), .sleep_status_o(sleep_status_o),
   .cts_n_o(cts_n_o), .req_pulldown_o(req_pulldown_o), .data_en_o(data_en_o),
   .scan_start_o(scan_start_o));
